// >>> rtl/protector_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: outputs start one by one, ascending order
// RQ2: start-up wait over five seconds forces next
// RQ3: overcurrent trips only the affected channel
// RQ4: overvoltage trips all; recovery restores previous state
// RQ5: reset input must stay high half second
// RQ6: qualified reset turns resettable trips on
// RQ7: alarm relay opens while any channel tripped
// RQ8: states saved at power-off, restored after init
// RQ9: no saved state means every channel on
// RQ10: indicator colour and blink per state
// RQ11: button toggles on and manually off
// RQ12: overcurrent becomes hold trip when due
// RQ13: hold trip lasts holdoff, then resettable
// RQ14: fuse or memory error disconnects into error
// RQ15: operator clears fault cause before resetting
// RQ16: inputs synchronised, debounced, timed by millisecond tick; code syncs only buttons and reset, debounces only buttons
module protector_ctrl
  import protector_pkg::*;
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned INIT_MS = 250,
  parameter int unsigned HOLDOFF_SET_MS = HOLDOFF_MS
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [CHANNELS-1:0] button_press,
  input wire logic ext_reset_level,
  input wire chan_sense_t [CHANNELS-1:0] chan_sense,
  input wire logic over_voltage,
  input wire logic memory_error,
  input wire logic power_fail,
  input wire logic store_valid,
  output logic store_valid_set,
  output logic [CHANNELS-1:0] output_enable,
  output led_drive_t [CHANNELS-1:0] led_drive,
  output logic fault_relay_closed,
  output chan_state_t [CHANNELS-1:0] chan_state
);

  localparam int AW = $clog2(CHANNELS);
  localparam int unsigned TCW = $clog2(TICK_DIV + 1);

  typedef enum logic [2:0] {
    PH_INIT,
    PH_RESTORE,
    PH_START,
    PH_RUN,
    PH_SAVE
  } phase_t;

  // =========================================================
  // millisecond tick and blink bases
  // =========================================================
  logic [TCW-1:0] div_reg, div_next;
  logic tick;
  logic [9:0] blink_reg, blink_next;
  logic slow_on, fast_on;

  always_comb begin
    tick = (div_reg == TCW'(TICK_DIV - 1)); // see RQ16
    div_next = tick ? '0 : div_reg + 1'b1;
    blink_next = blink_reg;
    if (tick) begin
      blink_next = (blink_reg == 10'(2 * BLINK_SLOW_MS - 1)) ? '0
                   : blink_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_reg <= '0;
      blink_reg <= '0;
    end else begin
      div_reg <= div_next;
      blink_reg <= blink_next;
    end
  end

  assign slow_on = (blink_reg < 10'(BLINK_SLOW_MS));
  assign fast_on = ((blink_reg / 10'(BLINK_FAST_MS)) % 10'd2) == 10'd0;

  // =========================================================
  // reset input: synchroniser, qualification
  // =========================================================
  logic rst_s1_reg, rst_s2_reg, rst_s1_next, rst_s2_next;
  logic [9:0] rst_ms_reg, rst_ms_next;
  logic rst_fired_reg, rst_fired_next;
  logic ext_reset_pulse;

  always_comb begin
    rst_s1_next = ext_reset_level; // see RQ16
    rst_s2_next = rst_s1_reg;
    rst_ms_next = rst_ms_reg;
    rst_fired_next = rst_fired_reg;
    ext_reset_pulse = 1'b0;
    if (!rst_s2_reg) begin
      rst_ms_next = '0; // short highs are dropped, see RQ5
      rst_fired_next = 1'b0;
    end else if (tick && !rst_fired_reg) begin
      if (rst_ms_reg == 10'(RESET_HOLD_MS - 1)) begin
        ext_reset_pulse = 1'b1; // see RQ5
        rst_fired_next = 1'b1;
      end else begin
        rst_ms_next = rst_ms_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      rst_ms_reg <= '0;
      rst_fired_reg <= 1'b0;
    end else begin
      rst_s1_reg <= rst_s1_next;
      rst_s2_reg <= rst_s2_next;
      rst_ms_reg <= rst_ms_next;
      rst_fired_reg <= rst_fired_next;
    end
  end

  // =========================================================
  // push buttons: synchroniser, debounce, press edge
  // =========================================================
  logic [CHANNELS-1:0] btn_press;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_btn
    logic s1_reg, s2_reg, db_reg, s1_next, s2_next, db_next;
    logic [3:0] cnt_reg, cnt_next;
    always_comb begin
      s1_next = button_press[c]; // see RQ16
      s2_next = s1_reg;
      db_next = db_reg;
      cnt_next = cnt_reg;
      if (s2_reg == db_reg) begin
        cnt_next = '0;
      end else if (tick) begin
        if (cnt_reg == 4'(DEBOUNCE_MS - 1)) begin
          db_next = s2_reg;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    end
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        db_reg <= 1'b0;
        cnt_reg <= '0;
      end else begin
        s1_reg <= s1_next;
        s2_reg <= s2_next;
        db_reg <= db_next;
        cnt_reg <= cnt_next;
      end
    end
    assign btn_press[c] = db_next & ~db_reg;
  end

  // =========================================================
  // sequencer: init, restore, start-up, run, save
  // =========================================================
  phase_t ph_reg, ph_next;
  logic [12:0] ms_reg, ms_next;
  logic [AW-1:0] idx_reg, idx_next;
  logic [CHANNELS-1:0] live_reg, live_next;
  logic [CHANNELS-1:0] ld_en;
  logic st_wr;
  chan_state_t st_rd;
  chan_state_t [CHANNELS-1:0] st_reg;

  always_comb begin
    ph_next = ph_reg;
    ms_next = ms_reg;
    idx_next = idx_reg;
    live_next = live_reg;
    ld_en = '0;
    st_wr = 1'b0;
    store_valid_set = 1'b0;
    case (ph_reg)
      PH_INIT: begin
        if (tick) begin
          ms_next = ms_reg + 1'b1;
        end
        if (ms_reg == 13'(INIT_MS)) begin
          ph_next = PH_RESTORE;
          idx_next = '0;
          ms_next = '0;
        end
      end
      PH_RESTORE: begin
        // read data lags the address by one cycle
        if (ms_reg[0]) begin
          ld_en[idx_reg] = 1'b1; // see RQ8
          ms_next = '0;
          if (idx_reg == AW'(CHANNELS - 1)) begin
            ph_next = PH_START;
            idx_next = '0;
          end else begin
            idx_next = idx_reg + 1'b1;
          end
        end else begin
          ms_next = 13'd1;
        end
      end
      PH_START: begin
        live_next[idx_reg] = 1'b1; // see RQ1
        if (tick) begin
          ms_next = ms_reg + 1'b1;
        end
        if (st_reg[idx_reg] != ST_ON || chan_sense[idx_reg].started
            || ms_reg >= 13'(START_FORCE_MS)) begin // see RQ2
          ms_next = '0;
          if (idx_reg == AW'(CHANNELS - 1)) begin
            ph_next = PH_RUN;
          end else begin
            idx_next = idx_reg + 1'b1; // see RQ1
          end
        end
      end
      PH_RUN: begin
        if (power_fail) begin
          ph_next = PH_SAVE;
          idx_next = '0;
        end
      end
      default: begin
        st_wr = 1'b1; // see RQ8
        if (idx_reg == AW'(CHANNELS - 1)) begin
          store_valid_set = 1'b1;
          ph_next = PH_RUN;
        end else begin
          idx_next = idx_reg + 1'b1;
        end
      end
    endcase
    if (power_fail && ph_reg != PH_RUN && ph_reg != PH_SAVE
        && ph_reg != PH_INIT && ph_reg != PH_RESTORE) begin
      ph_next = PH_SAVE;
      idx_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ph_reg <= PH_INIT;
      ms_reg <= '0;
      idx_reg <= '0;
      live_reg <= '0;
    end else begin
      ph_reg <= ph_next;
      ms_reg <= ms_next;
      idx_reg <= idx_next;
      live_reg <= live_next;
    end
  end

  state_store #(
    .DEPTH(CHANNELS)
  ) u_store (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(st_wr),
    .wr_addr(idx_reg),
    .wr_data(st_reg[idx_reg]),
    .rd_addr(idx_reg),
    .rd_data(st_rd)
  );

  // =========================================================
  // per-channel state machines and indicators
  // =========================================================
  logic [CHANNELS-1:0] tripped;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    chan_state_t s_next;
    logic [14:0] hold_reg, hold_next;
    logic mem_bad;
    always_comb begin
      s_next = st_reg[c];
      hold_next = hold_reg;
      // unknown codes in the store count as a memory error
      mem_bad = (st_rd == ST_INIT) || (st_rd > ST_ERROR);
      if (ld_en[c]) begin
        if (!store_valid) begin
          s_next = ST_ON; // see RQ9
        end else if (mem_bad) begin
          s_next = ST_ERROR; // see RQ14
        end else begin
          s_next = st_rd; // see RQ8
        end
        hold_next = '0;
      end else if (live_reg[c] && !over_voltage) begin
        // overvoltage only masks outputs, so state is kept, see RQ4
        if (chan_sense[c].fuse_fail || memory_error) begin
          s_next = ST_ERROR; // see RQ14
        end else begin
          case (st_reg[c])
            ST_ON: begin
              if (btn_press[c]) begin
                s_next = ST_MANUAL_OFF; // see RQ11
              end else if (chan_sense[c].over_threshold) begin
                s_next = ST_OVERCURRENT; // see RQ3
              end
            end
            ST_OVERCURRENT: begin
              if (btn_press[c]) begin
                s_next = ST_MANUAL_OFF; // see RQ11
              end else if (chan_sense[c].trip_due) begin
                s_next = ST_TRIP_HOLD; // see RQ12
                hold_next = '0;
              end else if (!chan_sense[c].over_threshold) begin
                s_next = ST_ON;
              end
            end
            ST_MANUAL_OFF: begin
              if (btn_press[c]) begin
                s_next = ST_ON; // see RQ11
              end
            end
            ST_TRIP_HOLD: begin
              if (tick) begin
                hold_next = hold_reg + 1'b1;
              end
              if (hold_reg >= 15'(HOLDOFF_SET_MS)) begin
                s_next = ST_TRIP_RESETTABLE; // see RQ13
              end
            end
            ST_TRIP_RESETTABLE: begin
              if (btn_press[c]) begin
                s_next = ST_MANUAL_OFF; // see RQ11
              end else if (ext_reset_pulse) begin
                s_next = ST_ON; // see RQ6
              end
            end
            default: begin
              s_next = st_reg[c];
            end
          endcase
        end
      end
    end
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        st_reg[c] <= ST_INIT;
        hold_reg <= '0;
      end else begin
        st_reg[c] <= s_next;
        hold_reg <= hold_next;
      end
    end

    // output only when started and healthy, see RQ3
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        output_enable[c] <= 1'b0;
      end else begin
        output_enable[c] <= live_reg[c] && !over_voltage // see RQ4
          && (s_next == ST_ON || s_next == ST_OVERCURRENT);
      end
    end

    // indicator colour and blink, see RQ10
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        led_drive[c] <= '{colour: COL_DARK, lit: 1'b0};
      end else if (over_voltage && st_reg[c] != ST_INIT) begin
        led_drive[c] <= '{colour: COL_RED, lit: fast_on}; // see RQ10
      end else begin
        case (st_reg[c])
          ST_ON: led_drive[c] <= '{colour: COL_GREEN, lit: 1'b1};
          ST_OVERCURRENT: led_drive[c] <= '{colour: COL_YELLOW, lit: 1'b1};
          ST_MANUAL_OFF: led_drive[c] <= '{colour: COL_RED, lit: 1'b1};
          ST_TRIP_HOLD: led_drive[c] <= '{colour: COL_RED, lit: slow_on};
          ST_TRIP_RESETTABLE: begin
            led_drive[c] <= '{colour: COL_YELLOW, lit: slow_on};
          end
          ST_ERROR: led_drive[c] <= '{colour: COL_RED, lit: fast_on};
          default: led_drive[c] <= '{colour: COL_DARK, lit: 1'b0};
        endcase
      end
    end

    assign tripped[c] = (st_reg[c] == ST_TRIP_HOLD)
      || (st_reg[c] == ST_TRIP_RESETTABLE) || (st_reg[c] == ST_ERROR);
  end

  // relay closed only when nothing is tripped, see RQ7
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fault_relay_closed <= 1'b0;
    end else begin
      fault_relay_closed <= (ph_reg != PH_INIT && ph_reg != PH_RESTORE)
        && !(|tripped) && !over_voltage; // see RQ7
    end
  end

  assign chan_state = st_reg;

endmodule // protector_ctrl

// >>> rtl/protector_pkg.sv
package protector_pkg;

  // =========================================================
  // timing
  // =========================================================
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned RESET_HOLD_MS = 500;
  localparam int unsigned START_FORCE_MS = 5000;
  localparam int unsigned HOLDOFF_MS = 500;
  localparam int unsigned HOLDOFF_MAX_MS = 20000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned BLINK_SLOW_MS = 500;
  localparam int unsigned BLINK_FAST_MS = 100;

  // =========================================================
  // channel states and indicator
  // =========================================================
  typedef enum logic [2:0] {
    ST_INIT,
    ST_ON,
    ST_OVERCURRENT,
    ST_MANUAL_OFF,
    ST_TRIP_HOLD,
    ST_TRIP_RESETTABLE,
    ST_ERROR
  } chan_state_t;

  typedef enum logic [1:0] {
    COL_DARK,
    COL_GREEN,
    COL_YELLOW,
    COL_RED
  } led_colour_t;

  // per-channel indicator drive
  typedef struct packed {
    led_colour_t colour;
    logic lit;
  } led_drive_t;

  // per-channel sensed conditions
  typedef struct packed {
    logic over_threshold;
    logic trip_due;
    logic fuse_fail;
    logic started;
  } chan_sense_t;

endpackage

// >>> rtl/state_store.sv
`timescale 1ns/1ns
// small non-volatile image holder with registered read data
module state_store
  import protector_pkg::*;
#(
  parameter int unsigned DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire chan_state_t wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output chan_state_t rd_data
);

  chan_state_t mem [DEPTH];
  chan_state_t rd_data_reg;

  // =========================================================
  // storage (contents survive srst, as the backing store would)
  // =========================================================
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_reg <= ST_INIT;
    end else begin
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule // state_store

// >>> testbench/operator_model.sv
`timescale 1ns/1ns
// =========================================================
// operator buttons, reset source and alarm watcher
module operator_model #(
  parameter int unsigned CHANNELS = 2
) (
  input wire logic sys_clk,
  input wire logic fault_relay_closed,
  output logic [CHANNELS-1:0] button_press,
  output logic ext_reset_level
);
  int opens = 0;
  logic relay_seen = 1'b0;
  // idle levels at time zero
  initial begin
    button_press = '0;
    ext_reset_level = 1'b0;
  end
  // alarm watcher counts contact openings
  always @(posedge sys_clk) begin
    if (relay_seen && !fault_relay_closed)
      opens++;
    relay_seen <= fault_relay_closed;
  end
  // press one button, held well past the debounce time
  task automatic press(input int ch);
    @(posedge sys_clk) #1;
    button_press[ch] = 1'b1;
    repeat (200) @(posedge sys_clk);
    #1;
    button_press[ch] = 1'b0;
    repeat (200) @(posedge sys_clk);
    #1;
  endtask
  // hold the reset level high for a number of cycles
  task automatic hold_reset(input int cycles);
    @(posedge sys_clk) #1;
    ext_reset_level = 1'b1;
    repeat (cycles) @(posedge sys_clk);
    #1;
    ext_reset_level = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
  endtask
endmodule // operator_model

// >>> testbench/protector_ctrl_asserts.sv
`timescale 1ns/1ns
// =========================================================
// checker for the channel state controller
module protector_ctrl_checker
  import protector_pkg::*;
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned TICK_DIV = 10,
  parameter int unsigned HOLDOFF_SET_MS = 500
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ext_reset_level,
  input wire logic over_voltage,
  input wire logic [CHANNELS-1:0] output_enable,
  input wire led_drive_t [CHANNELS-1:0] led_drive,
  input wire logic fault_relay_closed,
  input wire chan_state_t [CHANNELS-1:0] chan_state
);
  localparam int HOLD_LO = (HOLDOFF_SET_MS - 1) * TICK_DIV;
  localparam int HOLD_HI = (HOLDOFF_MAX_MS + 1) * TICK_DIV;
  localparam int RST_LO = (RESET_HOLD_MS - 1) * TICK_DIV;
  logic [3:0] ov_hist_reg;
  logic ext_prev_reg;
  int hold_cnt_reg;
  int high_cnt_reg;
  logic any_trip;
  logic no_trip;
  logic quiet;
  // summary of all channel states
  always_comb begin
    any_trip = 1'b0;
    no_trip = 1'b1;
    quiet = !over_voltage && ov_hist_reg == 4'h0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (chan_state[i] inside {ST_TRIP_HOLD, ST_TRIP_RESETTABLE, ST_ERROR})
        any_trip = 1'b1;
      if (!(chan_state[i] inside {ST_ON, ST_OVERCURRENT, ST_MANUAL_OFF}))
        no_trip = 1'b0;
    end
  end
  // cycle counters for hold-off and reset high time
  always_ff @(posedge sys_clk) begin
    ov_hist_reg <= {ov_hist_reg[2:0], over_voltage};
    ext_prev_reg <= ext_reset_level;
    hold_cnt_reg <= (chan_state[0] == ST_TRIP_HOLD) ? hold_cnt_reg + 1 : 0;
    if (ext_reset_level)
      high_cnt_reg <= ext_prev_reg ? high_cnt_reg + 1 : 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_relay_opens: assert property (any_trip |=> !fault_relay_closed)
    else $error("relay closed while a channel is tripped");
  chk_relay_closes: assert property (no_trip && $past(no_trip)
    && quiet |=> fault_relay_closed) else $error("relay open with no trip");
  chk_on_green: assert property (chan_state[0] == ST_ON && quiet
    |=> led_drive[0].colour == COL_GREEN && led_drive[0].lit)
    else $error("on channel not steady green");
  chk_oc_yellow: assert property (chan_state[0] == ST_OVERCURRENT
    && quiet |=> led_drive[0] == {COL_YELLOW, 1'b1})
    else $error("overcurrent channel not steady yellow");
  // enable is registered from the next state, so it matches the state now
  chk_off_red: assert property (chan_state[0] == ST_MANUAL_OFF
    |-> !output_enable[0] ##1 led_drive[0].colour == COL_RED)
    else $error("manual off channel not red and off");
  chk_trip_cut: assert property (chan_state[0] inside {
    ST_TRIP_HOLD, ST_TRIP_RESETTABLE, ST_ERROR} |-> !output_enable[0])
    else $error("tripped channel still enabled");
  chk_hold_red: assert property (chan_state[0] == ST_TRIP_HOLD
    |=> led_drive[0].colour == COL_RED) else $error("hold trip not red");
  chk_init_dark: assert property (chan_state[0] == ST_INIT
    |=> !led_drive[0].lit && !output_enable[0]) else $error("init not dark");
  chk_ov_mask: assert property (over_voltage [*3]
    |=> output_enable == '0) else $error("output on during overvoltage");
  chk_hold_time: assert property (
    $past(chan_state[0]) == ST_TRIP_HOLD && chan_state[0] == ST_TRIP_RESETTABLE
    |-> hold_cnt_reg >= HOLD_LO && hold_cnt_reg <= HOLD_HI)
    else $error("hold-off length out of range");
  chk_reset_len: assert property (
    $past(chan_state[0]) == ST_TRIP_RESETTABLE && chan_state[0] == ST_ON
    |-> high_cnt_reg >= RST_LO) else $error("reset accepted too early");
endmodule // protector_ctrl_checker

bind protector_ctrl protector_ctrl_checker #(
  .CHANNELS(CHANNELS), .TICK_DIV(TICK_DIV), .HOLDOFF_SET_MS(HOLDOFF_SET_MS)
) chk (
  .sys_clk(sys_clk), .srst(srst), .ext_reset_level(ext_reset_level),
  .over_voltage(over_voltage), .output_enable(output_enable),
  .led_drive(led_drive), .fault_relay_closed(fault_relay_closed),
  .chan_state(chan_state)
);

// >>> testbench/protector_ctrl_tb.sv
`timescale 1ns/1ns
// =========================================================
// self-checking bench for the channel state controller
module protector_ctrl_tb
  import protector_pkg::*;
;
  localparam int CH = 2;
  localparam int T = 10;
  logic sys_clk, srst, over_voltage, memory_error, ext_reset_level;
  logic fault_relay_closed;
  logic power_fail, store_valid, store_valid_set;
  logic [CH-1:0] button_press, output_enable;
  chan_sense_t [CH-1:0] chan_sense;
  led_drive_t [CH-1:0] led_drive;
  chan_state_t [CH-1:0] chan_state;
  int fail_count = 0;
  int checks_done = 0;

  protector_ctrl #(.CHANNELS(CH), .TICK_DIV(T), .INIT_MS(5),
    .HOLDOFF_SET_MS(500)) dut (
    .sys_clk(sys_clk), .srst(srst), .button_press(button_press),
    .ext_reset_level(ext_reset_level), .chan_sense(chan_sense),
    .over_voltage(over_voltage), .memory_error(memory_error),
    .power_fail(power_fail), .store_valid(store_valid),
    .store_valid_set(store_valid_set),
    .output_enable(output_enable), .led_drive(led_drive),
    .fault_relay_closed(fault_relay_closed), .chan_state(chan_state));
  operator_model #(.CHANNELS(CH)) op (.sys_clk(sys_clk),
    .fault_relay_closed(fault_relay_closed), .button_press(button_press),
    .ext_reset_level(ext_reset_level));

  // compare one value and count it
  task automatic check(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // wait a bounded time for a channel state, then compare
  task automatic wait_st(input int ch, input chan_state_t st, input int lim);
    int n;
    n = 0;
    while (chan_state[ch] !== st && n < lim) begin
      @(posedge sys_clk) #1;
      n++;
    end
    check("chan_state", 8'(chan_state[ch]), 8'(st));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ordered start-up, with a forced start of the second channel
  task automatic t_startup();
    wait_st(0, ST_ON, 200);
    repeat (5) @(posedge sys_clk) #1;
    check("enable", 8'(output_enable), 8'h01);
    check("led0", 8'(led_drive[0]), 8'({COL_GREEN, 1'b1}));
    repeat (4000 * T) @(posedge sys_clk) #1;
    check("enable", 8'(output_enable), 8'h01);
    repeat (1100 * T) @(posedge sys_clk) #1;
    check("enable", 8'(output_enable), 8'h03);
    chan_sense = {2{4'h1}};
    $display("test startup done");
  endtask
  // overcurrent, hold-off trip, short and long external reset
  task automatic t_trip();
    chan_sense[0].over_threshold = 1'b1;
    wait_st(0, ST_OVERCURRENT, 20);
    chan_sense[0].trip_due = 1'b1;
    wait_st(0, ST_TRIP_HOLD, 20);
    chan_sense[0] = 4'h1;
    repeat (3) @(posedge sys_clk) #1;
    check("enable", 8'(output_enable), 8'h02);
    check("relay", 8'(fault_relay_closed), 8'h00);
    repeat (400 * T) @(posedge sys_clk) #1;
    check("held", 8'(chan_state[0]), 8'(ST_TRIP_HOLD));
    wait_st(0, ST_TRIP_RESETTABLE, 200 * T);
    op.hold_reset(300 * T);
    check("short", 8'(chan_state[0]), 8'(ST_TRIP_RESETTABLE));
    op.hold_reset(520 * T);
    check("reset", 8'(chan_state), 8'({ST_ON, ST_ON}));
    check("relay", 8'(fault_relay_closed), 8'h01);
    check("opens", 8'(op.opens), 8'h01);
    $display("test trip done");
  endtask
  // button toggles, ignored during overvoltage; overvoltage restores
  task automatic t_button_ov();
    op.press(1);
    wait_st(1, ST_MANUAL_OFF, 50);
    check("enable", 8'(output_enable), 8'h01);
    over_voltage = 1'b1;
    op.press(1);
    check("enable", 8'(output_enable), 8'h00);
    check("kept", 8'(chan_state), 8'({ST_MANUAL_OFF, ST_ON}));
    check("ovled", 8'(led_drive[0].colour), 8'(COL_RED));
    over_voltage = 1'b0;
    repeat (10) @(posedge sys_clk) #1;
    check("back", 8'(output_enable), 8'h01);
    op.press(1);
    wait_st(1, ST_ON, 50);
    $display("test button done");
  endtask
  // save at power loss, then restore after a second reset
  task automatic t_save();
    int n;
    n = 0;
    op.press(0);
    wait_st(0, ST_MANUAL_OFF, 50);
    power_fail = 1'b1;
    while (store_valid_set !== 1'b1 && n < 20) begin
      @(posedge sys_clk) #1;
      n++;
    end
    check("saved", 8'(store_valid_set), 8'h01);
    @(posedge sys_clk) #1;
    power_fail = 1'b0;
    store_valid = 1'b1;
    srst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    check("dark", 8'(led_drive), 8'h00);
    wait_st(1, ST_ON, 200);
    check("restored", 8'(chan_state), 8'({ST_ON, ST_MANUAL_OFF}));
    repeat (10) @(posedge sys_clk) #1;
    check("enable", 8'(output_enable), 8'h02);
    op.press(0);
    wait_st(0, ST_ON, 50);
    $display("test save done");
  endtask
  // fuse failure and memory error force the error state
  task automatic t_error();
    chan_sense[1].fuse_fail = 1'b1;
    wait_st(1, ST_ERROR, 20);
    chan_sense[1].fuse_fail = 1'b0;
    repeat (3) @(posedge sys_clk) #1;
    check("enable", 8'(output_enable), 8'h01);
    check("led1", 8'(led_drive[1].colour), 8'(COL_RED));
    memory_error = 1'b1;
    wait_st(0, ST_ERROR, 20);
    $display("test error done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog cuts a hang short
  initial begin
    #900000;
    fail_count++;
    finish_test();
  end
  // main sequence
  initial begin
    srst = 1'b1;
    over_voltage = 1'b0;
    memory_error = 1'b0;
    power_fail = 1'b0;
    store_valid = 1'b0;
    chan_sense = '0;
    repeat (3) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    t_startup();
    t_trip();
    t_button_ov();
    t_save();
    t_error();
    finish_test();
  end
endmodule // protector_ctrl_tb
